// [core/btu_branch_unit.sv]
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/100ps
// ----------------------------------------------------------------
// branch target and condition unit with an apb register file
// ----------------------------------------------------------------
module btu_branch_unit (
    input wire logic clk,                 // core clock
    input wire logic nrst,                // asynchronous reset, active low
    input wire logic psel,                // apb select
    input wire logic penable,             // apb access phase
    input wire logic pwrite,              // apb direction, high for write
    input wire logic [7:0] paddr,         // apb byte address
    input wire logic [31:0] pwdata,       // apb write data
    output logic [31:0] prdata,           // apb read data
    output logic pready,                  // apb ready
    output logic pslverr,                 // apb error, unmapped address
    output logic [63:0] next_fetch_addr,  // resolved next instruction address
    output logic branch_taken,            // last branch was taken
    output logic branch_done              // one-cycle pulse per resolved branch
);

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------

    // word alignment and the 32-bit mode cut, always the final step
    function automatic logic [63:0] fetch_form(input logic [63:0] addr, input logic m32);
        logic [63:0] res;
        res = {addr[63:2], 2'b00};
        if (m32) begin
            res = {32'h0000_0000, res[31:0]};
        end
        return res;
    endfunction

    // displacement with 0b00 appended, then sign extended to 64 bits
    function automatic logic [63:0] sext_word(input logic [23:0] disp, input int width);
        logic [63:0] res;
        res = 64'h0;
        for (int i = 0; i < 62; i++) begin
            res[i + 2] = (i < width) ? disp[i] : disp[width - 1];
        end
        return res;
    endfunction

    // ------------------------------------------------------------
    // architected state and control
    // ------------------------------------------------------------
    logic [31:0] instr;            // branch instruction word
    btu_pkg::btu_form_type form;   // target form of the instruction
    logic mode32;                  // 32-bit mode of the 64-bit core
    logic [63:0] cur_addr;         // address of the branch itself
    logic [63:0] return_address_reg; // link target register
    logic [63:0] loop_counter_reg; // counter and indirect target register
    logic [31:0] condition_reg;    // 32 condition bits, bit 0 is the msb
    logic st_taken;                // status: last branch taken
    logic st_dec;                  // status: counter was decremented
    logic st_link;                 // status: return register was written
    logic st_done;                 // status: at least one branch resolved
    logic [63:0] next_addr;        // resolved fetch address
    logic [31:0] rd_data;          // read data held from the setup phase
    logic rd_err;                  // error held from the setup phase

    // ------------------------------------------------------------
    // instruction fields
    // ------------------------------------------------------------
    logic [23:0] long_displacement; // unconditional displacement
    logic [13:0] cond_displacement; // conditional displacement
    logic absolute_select;          // displacement is an absolute address
    logic link_update;              // write return address register
    logic [4:0] branch_options;     // counter and condition test code
    logic [4:0] cond_bit_index;     // condition bit to test
    logic cond_bit;                 // value of the selected condition bit

    assign long_displacement = instr[btu_pkg::btu_pos_ld_hi:btu_pkg::btu_pos_ld_lo];
    assign cond_displacement = instr[btu_pkg::btu_pos_cd_hi:btu_pkg::btu_pos_cd_lo];
    assign absolute_select = instr[btu_pkg::btu_pos_abs];
    assign link_update = instr[btu_pkg::btu_pos_link];
    assign branch_options = instr[btu_pkg::btu_pos_bo_hi:btu_pkg::btu_pos_bo_lo];
    assign cond_bit_index = instr[btu_pkg::btu_pos_bi_hi:btu_pkg::btu_pos_bi_lo];

    // index 0 names the most significant bit of the condition register
    assign cond_bit = condition_reg[5'd31 - cond_bit_index];

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic setup_phase;  // first cycle of a transfer
    logic access_phase; // transfer completes this cycle
    logic wr_en;        // a write takes effect at this edge
    logic exec_go;      // write to the execute register
    logic addr_mapped;  // paddr names a register

    assign setup_phase = psel & ~penable;
    assign access_phase = psel & penable;
    assign wr_en = access_phase & pwrite;
    assign exec_go = wr_en & (paddr == btu_pkg::btu_off_exec);

    // zero wait states: the data was fetched during setup
    assign pready = access_phase;
    assign pslverr = access_phase & rd_err;
    assign prdata = rd_data;

    // offsets laid out as aligned words, anything else is an error
    always_comb begin
        if (paddr == btu_pkg::btu_off_instr) begin
            addr_mapped = 1'b1;
        end else if (paddr == btu_pkg::btu_off_ctrl) begin
            addr_mapped = 1'b1;
        end else if (paddr[1:0] == 2'b00 && paddr >= btu_pkg::btu_off_cia_lo
                     && paddr <= btu_pkg::btu_off_next_hi) begin
            addr_mapped = 1'b1;
        end else begin
            addr_mapped = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // branch resolution
    // ------------------------------------------------------------
    logic dec;                     // options ask for a decrement
    logic [63:0] next_count;       // counter value after the branch
    logic opt_decision;            // options allow the branch
    logic next_taken;              // branch will be taken
    logic [63:0] next_target;      // raw target before alignment
    logic [63:0] seq_addr;         // sequential address after the branch
    logic [63:0] next_fetch;       // final fetch address

    btu_cond_eval u_cond (
        .branch_options(branch_options),
        .cond_bit(cond_bit),
        .loop_count(loop_counter_reg),
        .mode32(mode32),
        .decrement(dec),
        .next_count(next_count),
        .decision(opt_decision)
    );

    // target and taken decision for each form
    always_comb begin
        seq_addr = fetch_form(cur_addr + btu_pkg::btu_inst_step, mode32);
        next_taken = opt_decision;
        next_target = loop_counter_reg;
        case (form)
            btu_pkg::btu_form_imm: begin
                // unconditional forms ignore the option field entirely
                next_taken = 1'b1;
                if (absolute_select) begin
                    next_target = sext_word(long_displacement, 24);
                end else begin
                    next_target = cur_addr + sext_word(long_displacement, 24);
                end
            end
            btu_pkg::btu_form_cond: begin
                if (absolute_select) begin
                    next_target = sext_word({10'h000, cond_displacement}, 14);
                end else begin
                    next_target = cur_addr
                        + sext_word({10'h000, cond_displacement}, 14);
                end
            end
            btu_pkg::btu_form_ret: begin
                // old value is the target, even when the link also writes it
                next_target = return_address_reg;
            end
            btu_pkg::btu_form_cnt: begin
                // counter read before its decrement lands
                next_target = loop_counter_reg;
            end
            default: begin
                next_target = seq_addr;
            end
        endcase
        if (next_taken) begin
            next_fetch = fetch_form(next_target, mode32);
        end else begin
            next_fetch = seq_addr;
        end
    end

    // ------------------------------------------------------------
    // software-written registers
    // ------------------------------------------------------------

    // instruction word and control
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            instr <= btu_pkg::btu_rst_instr;
            form <= btu_pkg::btu_form_imm;
            mode32 <= btu_pkg::btu_rst_ctrl[btu_pkg::btu_pos_ctrl_mode32];
        end else if (wr_en) begin
            if (paddr == btu_pkg::btu_off_instr) begin
                instr <= pwdata;
            end else if (paddr == btu_pkg::btu_off_ctrl) begin
                form <= btu_pkg::btu_form_type'(
                    pwdata[btu_pkg::btu_pos_ctrl_form_hi:btu_pkg::btu_pos_ctrl_form_lo]);
                mode32 <= pwdata[btu_pkg::btu_pos_ctrl_mode32];
            end
        end
    end

    // current instruction address
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cur_addr <= btu_pkg::btu_rst_addr;
        end else if (wr_en && paddr == btu_pkg::btu_off_cia_lo) begin
            cur_addr[31:0] <= pwdata;
        end else if (wr_en && paddr == btu_pkg::btu_off_cia_hi) begin
            cur_addr[63:32] <= pwdata;
        end
    end

    // condition register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            condition_reg <= btu_pkg::btu_rst_cond;
        end else if (wr_en && paddr == btu_pkg::btu_off_cond) begin
            condition_reg <= pwdata;
        end
    end

    // ------------------------------------------------------------
    // registers written by software and by the branch
    // ------------------------------------------------------------

    // return address register; one apb write per cycle, so an execute
    // and a software load never meet at the same edge
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            return_address_reg <= btu_pkg::btu_rst_addr;
        end else if (exec_go && link_update) begin
            // written for every form, taken or not
            return_address_reg <= seq_addr;
        end else if (wr_en && paddr == btu_pkg::btu_off_ret_lo) begin
            return_address_reg[31:0] <= pwdata;
        end else if (wr_en && paddr == btu_pkg::btu_off_ret_hi) begin
            return_address_reg[63:32] <= pwdata;
        end
    end

    // loop counter register; unconditional form never counts
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            loop_counter_reg <= btu_pkg::btu_rst_addr;
        end else if (exec_go && form != btu_pkg::btu_form_imm) begin
            loop_counter_reg <= next_count;
        end else if (wr_en && paddr == btu_pkg::btu_off_cnt_lo) begin
            loop_counter_reg[31:0] <= pwdata;
        end else if (wr_en && paddr == btu_pkg::btu_off_cnt_hi) begin
            loop_counter_reg[63:32] <= pwdata;
        end
    end

    // ------------------------------------------------------------
    // branch outcome
    // ------------------------------------------------------------

    // outcome is replaced on each execute; software never clears it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_taken <= 1'b0;
            st_dec <= 1'b0;
            st_link <= 1'b0;
            st_done <= 1'b0;
            next_addr <= btu_pkg::btu_rst_addr;
        end else if (exec_go) begin
            st_taken <= next_taken;
            st_dec <= dec && form != btu_pkg::btu_form_imm;
            st_link <= link_update;
            st_done <= 1'b1;
            next_addr <= next_fetch;
        end
    end

    // one-cycle pulse after each resolution
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            branch_done <= 1'b0;
        end else begin
            branch_done <= exec_go;
        end
    end

    assign next_fetch_addr = next_addr;
    assign branch_taken = st_taken;

    // ------------------------------------------------------------
    // read data, captured in the setup phase
    // ------------------------------------------------------------

    // capture at the end of setup so prdata comes from a flip-flop
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rd_data <= 32'h0000_0000;
            rd_err <= 1'b0;
        end else if (setup_phase) begin
            rd_err <= ~addr_mapped;
            if (pwrite) begin
                rd_data <= 32'h0000_0000;
            end else if (paddr == btu_pkg::btu_off_instr) begin
                rd_data <= instr;
            end else if (paddr == btu_pkg::btu_off_ctrl) begin
                rd_data <= {29'h0, mode32, form};
            end else if (paddr == btu_pkg::btu_off_cia_lo) begin
                rd_data <= cur_addr[31:0];
            end else if (paddr == btu_pkg::btu_off_cia_hi) begin
                rd_data <= cur_addr[63:32];
            end else if (paddr == btu_pkg::btu_off_ret_lo) begin
                rd_data <= return_address_reg[31:0];
            end else if (paddr == btu_pkg::btu_off_ret_hi) begin
                rd_data <= return_address_reg[63:32];
            end else if (paddr == btu_pkg::btu_off_cnt_lo) begin
                rd_data <= loop_counter_reg[31:0];
            end else if (paddr == btu_pkg::btu_off_cnt_hi) begin
                rd_data <= loop_counter_reg[63:32];
            end else if (paddr == btu_pkg::btu_off_cond) begin
                rd_data <= condition_reg;
            end else if (paddr == btu_pkg::btu_off_status) begin
                rd_data <= {28'h0, st_done, st_link, st_dec, st_taken};
            end else if (paddr == btu_pkg::btu_off_next_lo) begin
                rd_data <= next_addr[31:0];
            end else if (paddr == btu_pkg::btu_off_next_hi) begin
                rd_data <= next_addr[63:32];
            end else begin
                // execute register and unmapped space read as zero
                rd_data <= 32'h0000_0000;
            end
        end
    end

endmodule

// [core/btu_cond_eval.sv]
`timescale 1ns/100ps
// ----------------------------------------------------------------
// branch options decision, purely combinational
// ----------------------------------------------------------------
module btu_cond_eval (
    input wire logic [4:0] branch_options, // bit 4 is the first option bit
    input wire logic cond_bit,             // selected condition register bit
    input wire logic [63:0] loop_count,    // loop counter before this branch
    input wire logic mode32,               // 32-bit mode
    output logic decrement,                // counter is to be decremented
    output logic [63:0] next_count,        // counter after this branch
    output logic decision                  // options allow the branch
);
    logic counter_zero; // tested counter bits are all zero
    logic count_ok;     // counter part of the test holds
    logic cond_ok;      // condition part of the test holds

    // option bit 2 clear asks for a decrement in every code
    always_comb begin
        decrement = ~branch_options[2];
        // whole 64-bit register counts down, whatever the mode
        next_count = decrement ? loop_count - 64'h1 : loop_count;
        // in 32-bit mode only the low word is tested
        if (mode32) begin
            counter_zero = (next_count[31:0] == 32'h0);
        end else begin
            counter_zero = (next_count == 64'h0);
        end
        // bit 1 picks zero or nonzero; ignored when no decrement
        if (branch_options[2]) begin
            count_ok = 1'b1;
        end else begin
            count_ok = branch_options[1] ? counter_zero : ~counter_zero;
        end
        // bit 4 set drops the condition test; bit 3 is the wanted value
        if (branch_options[4]) begin
            cond_ok = 1'b1;
        end else begin
            cond_ok = (cond_bit == branch_options[3]);
        end
        // bit 0 and, when bit 4 is set, bit 3 never reach the result
        decision = count_ok & cond_ok;
    end
endmodule

// [core/btu_pkg.sv]
package btu_pkg;

    // ------------------------------------------------------------
    // register byte offsets on the apb bus
    // ------------------------------------------------------------
    localparam logic [7:0] btu_off_instr = 8'h00;   // branch instruction word
    localparam logic [7:0] btu_off_ctrl = 8'h04;    // form select and mode
    localparam logic [7:0] btu_off_cia_lo = 8'h08;  // current address, low half
    localparam logic [7:0] btu_off_cia_hi = 8'h0c;  // current address, high half
    localparam logic [7:0] btu_off_ret_lo = 8'h10;  // return address register, low
    localparam logic [7:0] btu_off_ret_hi = 8'h14;  // return address register, high
    localparam logic [7:0] btu_off_cnt_lo = 8'h18;  // loop counter register, low
    localparam logic [7:0] btu_off_cnt_hi = 8'h1c;  // loop counter register, high
    localparam logic [7:0] btu_off_cond = 8'h20;    // condition register
    localparam logic [7:0] btu_off_exec = 8'h24;    // write: resolve one branch
    localparam logic [7:0] btu_off_status = 8'h28;  // outcome of last branch
    localparam logic [7:0] btu_off_next_lo = 8'h2c; // resolved fetch address, low
    localparam logic [7:0] btu_off_next_hi = 8'h30; // resolved fetch address, high

    // ------------------------------------------------------------
    // field positions (lsb numbering of the 32-bit instruction)
    // ------------------------------------------------------------
    localparam int btu_pos_link = 0;         // link update bit
    localparam int btu_pos_abs = 1;          // absolute select bit
    localparam int btu_pos_ld_lo = 2;        // long displacement, low bit
    localparam int btu_pos_ld_hi = 25;       // long displacement, high bit
    localparam int btu_pos_cd_lo = 2;        // conditional displacement, low bit
    localparam int btu_pos_cd_hi = 15;       // conditional displacement, high bit
    localparam int btu_pos_bi_lo = 16;       // condition bit index, low bit
    localparam int btu_pos_bi_hi = 20;       // condition bit index, high bit
    localparam int btu_pos_bo_lo = 21;       // branch options, low bit
    localparam int btu_pos_bo_hi = 25;       // branch options, high bit
    localparam int btu_pos_ctrl_form_lo = 0; // control: form select, low bit
    localparam int btu_pos_ctrl_form_hi = 1; // control: form select, high bit
    localparam int btu_pos_ctrl_mode32 = 2;  // control: 32-bit mode
    localparam int btu_pos_st_taken = 0;     // status: branch taken
    localparam int btu_pos_st_dec = 1;       // status: counter decremented
    localparam int btu_pos_st_link = 2;      // status: return register written
    localparam int btu_pos_st_done = 3;      // status: a branch was resolved
    localparam int btu_zero_test_m32 = 32;   // counter test start, 32-bit mode
    localparam int btu_zero_test_m64 = 0;    // counter test start, 64-bit mode

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [31:0] btu_rst_instr = 32'h0000_0000;
    localparam logic [2:0] btu_rst_ctrl = 3'h0;
    localparam logic [63:0] btu_rst_addr = 64'h0000_0000_0000_0000;
    localparam logic [31:0] btu_rst_cond = 32'h0000_0000;
    localparam logic [63:0] btu_inst_step = 64'h0000_0000_0000_0004; // one word

    // ------------------------------------------------------------
    // target forms
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        btu_form_imm = 2'b00,  // unconditional, long displacement
        btu_form_cond = 2'b01, // conditional, conditional displacement
        btu_form_ret = 2'b10,  // conditional, through return register
        btu_form_cnt = 2'b11   // conditional, through loop counter
    } btu_form_type;

endpackage

// [dv/btu_apb_master.sv]
`timescale 1ns/100ps
// ----------------------------------------------------------------
// pipeline side: loads the unit's registers and fires branches
// ----------------------------------------------------------------
module btu_apb_master (
    input wire logic clk,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [31:0] prdata,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata
);
    logic [31:0] rdat;  // read data taken at the ready edge
    logic err;  // slave error taken at that same edge
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    // request held until ready is seen; only the bench watchdog ends a wait
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1) @(posedge clk);
        rdat = prdata;
        err = pslverr;
        // stale write data is inverted so it can never pass for fresh data
        {psel, penable, pwdata} <= {2'h0, ~d};
    endtask
endmodule

// [dv/btu_branch_unit_checker.sv]
`timescale 1ns/100ps
// ----------------------------------------------------------------
// port timing checks
// ----------------------------------------------------------------
module btu_branch_unit_checker (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [7:0] paddr,
    input wire logic [63:0] next_fetch_addr,
    input wire logic branch_taken,
    input wire logic branch_done
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    logic acc;  // access cycle of any transfer
    logic exec;  // access cycle of the resolve write
    assign acc = psel && penable;
    assign exec = acc && pwrite && paddr == 8'h24;
    a_ready_now: assert property (acc |-> pready) else $error("ready late");
    a_ready_idle: assert property (!psel |-> !pready && !pslverr) else $error("ready idle");
    a_done_pulse: assert property (exec |=> branch_done ##1 !branch_done) else $error("done");
    a_done_cause: assert property (branch_done |-> $past(exec)) else $error("stray done");
    a_fetch_align: assert property (next_fetch_addr[1:0] == 2'h0) else $error("align");
    a_fetch_hold: assert property ($changed(next_fetch_addr) |-> branch_done)
        else $error("fetch");
    a_taken_hold: assert property ($changed(branch_taken) |-> branch_done) else $error("taken");
    a_bad_addr: assert property (acc && paddr > 8'h30 |-> pslverr) else $error("no error");
    c_taken: cover property (branch_done && branch_taken);
    c_not_taken: cover property (branch_done && !branch_taken);
    c_error: cover property (pslverr);
endmodule
bind btu_branch_unit btu_branch_unit_checker u_chk (
    .clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pready(pready), .pslverr(pslverr), .paddr(paddr),
    .next_fetch_addr(next_fetch_addr), .branch_taken(branch_taken),
    .branch_done(branch_done));

// [dv/test_branch_target_and_condition_unit.sv]
`timescale 1ns/100ps
module test_branch_target_and_condition_unit;
    typedef struct packed {logic [31:0] ins; logic [2:0] ctl; logic [63:0] cia, cnt;
        logic [31:0] cr; logic [63:0] nxt; logic tk;} btu_row_type;
    logic clk = 1'h0;
    logic nrst = 1'h0;
    logic psel, penable, pwrite, pready, pslverr, branch_taken, branch_done;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [63:0] next_fetch_addr, c;
    logic dec;  // row asks for a counter decrement
    logic [319:0] v;  // register words of one case, lowest offset first
    int fails = 0;
    int num_checks = 0;
    btu_row_type rows [12] = '{
        '{32'h03fffff1, 3'h0, 64'h1000, 64'h7, 32'h0, 64'hff0, 1'h1},
        '{32'h00000102, 3'h0, 64'h1000, 64'h7, 32'h0, 64'h100, 1'h1},
        '{32'h00830040, 3'h1, 64'h1000, 64'h7, 32'hefffffff, 64'h1040, 1'h1},
        '{32'h0180fffe, 3'h1, 64'h1000, 64'h7, 32'h80000000, 64'hfffffffffffffffc, 1'h1},
        '{32'h00200040, 3'h1, 64'h1000, 64'h1, 32'h0, 64'h1004, 1'h0},
        '{32'h01400040, 3'h1, 64'h1000, 64'h1, 32'h80000000, 64'h1040, 1'h1},
        '{32'h00400040, 3'h5, 64'h5fffffff0, 64'h100000001, 32'h0, 64'h30, 1'h1},
        '{32'h02800001, 3'h2, 64'h1000, 64'h7, 32'h0, 64'h2000, 1'h1},
        '{32'h00800001, 3'h2, 64'h1000, 64'h7, 32'h80000000, 64'h1004, 1'h0},
        '{32'h02000000, 3'h3, 64'h1000, 64'h3007, 32'h0, 64'h3004, 1'h1},
        '{32'h01000040, 3'h1, 64'h1000, 64'h7, 32'h80000000, 64'h1040, 1'h1},
        '{32'h03600001, 3'h7, 64'h100001000, 64'h1, 32'h0, 64'h0, 1'h1}};
    always #2 clk = ~clk;
    btu_branch_unit dut (.*);
    btu_apb_master bus (.*);
    task automatic cmp(input logic [63:0] g, input logic [63:0] x);
        num_checks++;
        if (g !== x) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask
    task automatic end_of_test;
        $display("checks=%0d fails=%0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // watchdog: the whole run needs under six hundred cycles
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        end_of_test;
    end
    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'h1;
        foreach (rows[i]) begin
            v = {32'h0, rows[i].cr, rows[i].cnt, 64'h2003, rows[i].cia, 29'h0, rows[i].ctl, rows[i].ins};
            for (int k = 0; k < 10; k++) bus.xfer(1'h1, 8'(4 * k), v[32 * k +: 32]);
            @(negedge clk);
            cmp(branch_done, 1'h1);
            cmp(next_fetch_addr, rows[i].nxt);
            cmp(branch_taken, rows[i].tk);
            dec = rows[i].ctl[1:0] != 2'h0 && !rows[i].ins[23];
            bus.xfer(1'h0, 8'h18, 32'h0);
            c[31:0] = bus.rdat;
            bus.xfer(1'h0, 8'h1c, 32'h0);
            c[63:32] = bus.rdat;
            cmp(c, rows[i].cnt - dec);
            bus.xfer(1'h0, 8'h10, 32'h0);
            cmp(bus.rdat,
                rows[i].ins[0] ? rows[i].cia[31:0] + 32'h4 : 32'h2003);
            bus.xfer(1'h0, 8'h28, 32'h0);
            cmp(bus.rdat, {28'h0, 1'h1, rows[i].ins[0], dec, rows[i].tk});
            bus.xfer(1'h0, 8'h2c, 32'h0);
            cmp(bus.rdat, rows[i].nxt[31:0]);
        end
        nrst <= 1'h0;
        @(negedge clk);
        cmp(branch_taken, 1'h0);
        cmp(next_fetch_addr, 64'h0);
        cmp(branch_done, 1'h0);
        @(posedge clk);
        nrst <= 1'h1;
        bus.xfer(1'h1, 8'h28, 32'hf);
        bus.xfer(1'h0, 8'h28, 32'h0);
        cmp(bus.rdat, 32'h0);
        bus.xfer(1'h0, 8'h34, 32'h0);
        cmp({bus.err, bus.rdat}, 33'h100000000);
        end_of_test;
    end
endmodule
